/* File: design/modbus_port_defs.vh */
// Register offsets, field positions, reset values and timing counts of the Modbus port
`ifndef MODBUS_PORT_DEFS_VH
`define MODBUS_PORT_DEFS_VH

// Clock and time base
`define CLK_HZ 20000000
`define MS_PER_S 1000
`define CLKS_PER_MS_CALC (`CLK_HZ / `MS_PER_S)
`define MS_PER_TENTH 100

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_OWN_ADDR 8'h04
`define REG_REPLY_TMO 8'h08
`define REG_LEAD_MS 8'h0C
`define REG_IP_NEXT 8'h10
`define REG_IP_LIVE 8'h14
`define REG_NET_MASK 8'h18
`define REG_NEXT_HOP 8'h1C
`define REG_TCP_PORT 8'h20
`define REG_STATUS 8'h24
`define REG_MAP_SEL 8'h28
`define REG_MAP_UNIT 8'h2C
`define REG_MAP_IP 8'h30

// Control register fields
`define CTRL_MASTER 0
`define CTRL_HI_FIRST 1
`define CTRL_PAR_LO 2
`define CTRL_PAR_HI 3
`define CTRL_TWO_STOP 4
`define CTRL_BAUD_LO 5
`define CTRL_BAUD_HI 7
`define CTRL_RESTART 8

// Parity codes
`define PAR_NONE 2'h0
`define PAR_EVEN 2'h1
`define PAR_ODD 2'h2

// Reset values
`define RST_CTRL 9'h083
`define RST_OWN_ADDR 8'h01
`define RST_REPLY_TMO 8'h05
`define RST_LEAD_MS 8'h32
`define RST_IP 32'h0A000065
`define RST_NET_MASK 32'hFFFFFF00
`define RST_NEXT_HOP 32'h00000000
`define RST_TCP_PORT 16'h01F6

// Data bits per serial character
`define DATA_BITS 8

`endif

/* File: design/rtu_char_tx.v */
// Serial character transmitter: start, eight data bits, optional parity, one or two stops
module rtu_char_tx (
  input wire clk,
  input wire sys_rst,
  input wire start,
  input wire [7:0] data,
  input wire [1:0] parity,
  input wire two_stop,
  input wire [15:0] bit_clks,
  output wire ready,
  output reg txd
);
`include "modbus_port_defs.vh"

  // Bit phases of one character
  localparam PH_IDLE = 3'h0;
  localparam PH_START = 3'h1;
  localparam PH_DATA = 3'h2;
  localparam PH_PAR = 3'h3;
  localparam PH_STOP = 3'h4;

  reg [2:0] ph_q; // Current phase
  reg [15:0] div_q; // Clocks left in this bit
  reg [2:0] bit_q; // Data bit or stop bit index
  reg [7:0] sh_q; // Data shifter, LSB first
  reg par_q; // Running parity of data bits
  reg [1:0] pmode_q; // Parity mode held for the character
  reg two_q; // Stop count held for the character

  wire bit_end = (div_q == 16'h0000);

  // Accepts a new character only once the last stop bit has fully ended
  assign ready = (ph_q == PH_IDLE);

  // Bit sequencer; line idles high
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q <= PH_IDLE;
      div_q <= 16'h0000;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      pmode_q <= 2'h0;
      two_q <= 1'b0;
      txd <= 1'b1;
    end else begin
      if (!bit_end) div_q <= div_q - 16'h0001;
      case (ph_q)
        PH_IDLE: begin
          txd <= 1'b1;
          if (start) begin // Latch parity and stop count so a mid-frame write cannot tear them; bit_clks is not latched
            ph_q <= PH_START;
            sh_q <= data;
            par_q <= 1'b0;
            pmode_q <= parity;
            two_q <= two_stop;
            div_q <= bit_clks - 16'h0001;
            txd <= 1'b0;
          end
        end
        PH_START: if (bit_end) begin
          ph_q <= PH_DATA;
          bit_q <= 3'h0;
          txd <= sh_q[0];
          par_q <= par_q ^ sh_q[0];
          sh_q <= {1'b0, sh_q[7:1]};
          div_q <= bit_clks - 16'h0001;
        end
        PH_DATA: if (bit_end) begin // Always eight data bits
          div_q <= bit_clks - 16'h0001;
          if (bit_q == 3'h7) begin
            bit_q <= 3'h0;
            ph_q <= (pmode_q == `PAR_NONE) ? PH_STOP : PH_PAR;
            txd <= (pmode_q == `PAR_NONE) ? 1'b1 : (par_q ^ (pmode_q == `PAR_ODD));
          end else begin
            bit_q <= bit_q + 3'h1;
            txd <= sh_q[0];
            par_q <= par_q ^ sh_q[0];
            sh_q <= {1'b0, sh_q[7:1]};
          end
        end
        PH_PAR: if (bit_end) begin
          ph_q <= PH_STOP;
          bit_q <= 3'h0;
          txd <= 1'b1;
          div_q <= bit_clks - 16'h0001;
        end
        PH_STOP: if (bit_end) begin
          txd <= 1'b1;
          if (two_q && (bit_q == 3'h0)) begin
            bit_q <= 3'h1;
            div_q <= bit_clks - 16'h0001;
          end else begin
            ph_q <= PH_IDLE;
          end
        end
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

endmodule // rtu_char_tx

/* File: design/modbus_port.v */
// Modbus RTU/TCP port: frame timing, reply timeout, address match, word order, IP settings
`include "modbus_port_defs.vh"
module modbus_port #(
  parameter CLKS_PER_MS = `CLKS_PER_MS_CALC,
  parameter MAP_N = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_last,
  output wire tx_ready,
  output wire txd,
  output reg line_drive,
  input wire reply_seen,
  output reg reply_ok,
  output reg no_reply,
  input wire rx_addr_valid,
  input wire [7:0] rx_addr,
  output reg rx_accept,
  input wire tcp_req_valid,
  input wire [7:0] tcp_req_unit,
  output reg tcp_req_accept,
  output reg [7:0] tcp_req_unit_out,
  input wire tcp_q_valid,
  input wire [7:0] tcp_q_unit,
  input wire tcp_reply_seen,
  output reg tcp_q_found,
  output reg [31:0] tcp_dest_ip,
  output reg [31:0] tcp_hop_ip,
  output reg tcp_q_done,
  output reg tcp_no_reply,
  output wire [15:0] tcp_port,
  output wire [31:0] own_ip,
  input wire wo_valid,
  input wire wo_is32,
  input wire wo_master_side,
  input wire wo_map_hi_first,
  input wire [31:0] wo_value,
  output reg [15:0] wo_reg_lo,
  output reg [15:0] wo_reg_hi,
  output reg wo_done
);
  // Frame states
  localparam S_IDLE = 3'h0;
  localparam S_LEAD = 3'h1;
  localparam S_SEND = 3'h2;
  localparam S_DRAIN = 3'h3;
  localparam S_WAIT = 3'h4;
  // Bit time in clocks for a baud code; codes above 5 fall back to 38400
  function [15:0] bit_clocks;
    input [2:0] code;
    reg [31:0] quot; // Cut to 16 bits below
    begin
      case (code)
        3'h0: quot = `CLK_HZ / 1200;
        3'h1: quot = `CLK_HZ / 2400;
        3'h2: quot = `CLK_HZ / 4800;
        3'h3: quot = `CLK_HZ / 9600;
        3'h4: quot = `CLK_HZ / 19200;
        default: quot = `CLK_HZ / 38400;
      endcase
      bit_clocks = quot[15:0];
    end
  endfunction
  // Split a value into lowest and next register; 32-bit pairs obey order
  function [31:0] order_words;
    input [31:0] val;
    input is32;
    input hi_first;
    begin
      if (!is32)
        order_words = {16'h0000, val[15:0]};
      else if (hi_first)
        order_words = {val[15:0], val[31:16]};
      else
        order_words = val;
    end
  endfunction

  // Software-visible settings
  reg [8:0] ctrl_q; // Mode, order, format, baud
  reg [7:0] own_addr_q; // Own station address
  reg [7:0] tmo_q; // Reply timeout, tenths of a second
  reg [7:0] lead_q; // Transmit lead delay, ms
  reg [31:0] ip_next_q; // Written own IP, waits for restart
  reg [31:0] ip_live_q; // Own IP in use
  reg [31:0] mask_q; // Subnet mask
  reg [31:0] hop_q; // Next-hop router
  reg [15:0] port_q; // TCP port
  reg [7:0] map_sel_q; // Unit map entry selected for writes
  reg [7:0] map_unit_q [0:MAP_N-1]; // Unit number keys
  reg [31:0] map_ip_q [0:MAP_N-1]; // Destination IPs
  reg [7:0] tmo_cnt_q; // Serial timeouts counted, saturating

  // Frame engine state
  reg [2:0] st_q;
  reg [14:0] pre_q; // Millisecond prescaler
  reg [15:0] ms_q; // Elapsed ms in lead or wait
  reg [7:0] gap_q; // Ms since last frame ended, saturating
  reg is_query_q; // Frame under way is a master query
  reg [15:0] tcp_ms_q; // TCP reply wait, ms
  reg tcp_wait_q; // TCP query outstanding
  wire cfg_master = ctrl_q[`CTRL_MASTER];
  wire cfg_hi_first = ctrl_q[`CTRL_HI_FIRST];
  wire [31:0] tmo_full = tmo_q * `MS_PER_TENTH;
  wire [15:0] tmo_ms = tmo_full[15:0];
  wire uart_ready;
  wire ms_tick = (pre_q == CLKS_PER_MS - 1);
  wire lead_start = (st_q == S_IDLE) && tx_valid &&
                    (!cfg_master || (gap_q >= lead_q));
  wire map_wr = reg_wr && (map_sel_q < MAP_N);
  assign tx_ready = (st_q == S_SEND) && uart_ready;
  assign tcp_port = port_q;
  assign own_ip = ip_live_q;
  // Register writes; restart bit promotes the written IP
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `RST_CTRL;
      own_addr_q <= `RST_OWN_ADDR;
      tmo_q <= `RST_REPLY_TMO;
      lead_q <= `RST_LEAD_MS;
      ip_next_q <= `RST_IP;
      ip_live_q <= `RST_IP;
      mask_q <= `RST_NET_MASK;
      hop_q <= `RST_NEXT_HOP;
      port_q <= `RST_TCP_PORT;
      map_sel_q <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          ctrl_q <= {1'b0, reg_wdata[7:0]}; // Restart bit never stored
          if (reg_wdata[`CTRL_RESTART]) ip_live_q <= ip_next_q;
        end
        `REG_OWN_ADDR: own_addr_q <= reg_wdata[7:0];
        `REG_REPLY_TMO: tmo_q <= reg_wdata[7:0];
        `REG_LEAD_MS: lead_q <= reg_wdata[7:0];
        `REG_IP_NEXT: ip_next_q <= reg_wdata;
        `REG_NET_MASK: mask_q <= reg_wdata;
        `REG_NEXT_HOP: hop_q <= reg_wdata;
        `REG_TCP_PORT: port_q <= reg_wdata[15:0];
        `REG_MAP_SEL: map_sel_q <= reg_wdata[7:0];
        default: ; // Read-only or unmapped: ignored
      endcase
    end
  end
  // Unit map entries; no reset so the array stays a plain memory
  always @(posedge clk) begin
    if (map_wr && (reg_addr == `REG_MAP_UNIT))
      map_unit_q[map_sel_q[$clog2(MAP_N)-1:0]] <= reg_wdata[7:0];
    if (map_wr && (reg_addr == `REG_MAP_IP))
      map_ip_q[map_sel_q[$clog2(MAP_N)-1:0]] <= reg_wdata;
  end
  // Read data one cycle after the strobe, zero otherwise
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= {23'h000000, ctrl_q};
        `REG_OWN_ADDR: reg_rdata <= {24'h000000, own_addr_q};
        `REG_REPLY_TMO: reg_rdata <= {24'h000000, tmo_q};
        `REG_LEAD_MS: reg_rdata <= {24'h000000, lead_q};
        `REG_IP_NEXT: reg_rdata <= ip_next_q;
        `REG_IP_LIVE: reg_rdata <= ip_live_q;
        `REG_NET_MASK: reg_rdata <= mask_q;
        `REG_NEXT_HOP: reg_rdata <= hop_q;
        `REG_TCP_PORT: reg_rdata <= {16'h0000, port_q};
        `REG_STATUS: reg_rdata <= {20'h00000, tcp_wait_q, st_q, tmo_cnt_q};
        `REG_MAP_SEL: reg_rdata <= {24'h000000, map_sel_q};
        default: reg_rdata <= 32'h00000000; // Unmapped reads as zero
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
  // Millisecond prescaler, restarted at each lead and driver release
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      pre_q <= 15'h0000;
    else if (ms_tick || lead_start || ((st_q == S_DRAIN) && uart_ready))
      pre_q <= 15'h0000;
    else
      pre_q <= pre_q + 15'h0001;
  end
  // Frame engine: lead, send, drain to last stop, then wait for reply if the frame is a master query with a nonzero timeout
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      ms_q <= 16'h0000;
      gap_q <= 8'hFF; // First query after reset needs no gap
      is_query_q <= 1'b0;
      line_drive <= 1'b0;
      reply_ok <= 1'b0;
      no_reply <= 1'b0;
      tmo_cnt_q <= 8'h00;
    end else begin
      reply_ok <= 1'b0;
      no_reply <= 1'b0;
      if (ms_tick && (gap_q != 8'hFF)) gap_q <= gap_q + 8'h01;
      if (ms_tick && (ms_q != 16'hFFFF)) ms_q <= ms_q + 16'h0001;
      case (st_q)
        S_IDLE: begin
          line_drive <= 1'b0;
          if (lead_start) begin // Driver on before first character
            st_q <= S_LEAD;
            ms_q <= 16'h0000;
            is_query_q <= cfg_master;
            line_drive <= 1'b1;
          end
        end
        S_LEAD: if (ms_q >= {8'h00, lead_q}) st_q <= S_SEND;
        S_SEND: if (tx_valid && tx_ready && tx_last) st_q <= S_DRAIN;
        S_DRAIN: begin
          // Released only once the final stop bit has left the line
          if (uart_ready) begin
            line_drive <= 1'b0;
            gap_q <= 8'h00;
            ms_q <= 16'h0000;
            if (!is_query_q) begin
              st_q <= S_IDLE;
            end else if (tmo_q == 8'h00) begin // Not waiting at all
              no_reply <= 1'b1;
              if (tmo_cnt_q != 8'hFF) tmo_cnt_q <= tmo_cnt_q + 8'h01;
              st_q <= S_IDLE;
            end else begin
              st_q <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (reply_seen) begin // Reply beats a timeout in the same cycle
            reply_ok <= 1'b1;
            st_q <= S_IDLE;
          end else if (ms_q >= tmo_ms) begin
            no_reply <= 1'b1;
            if (tmo_cnt_q != 8'hFF) tmo_cnt_q <= tmo_cnt_q + 8'h01;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // Serial characters to the line
  rtu_char_tx u_char_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(tx_valid && tx_ready),
    .data(tx_data),
    .parity(ctrl_q[`CTRL_PAR_HI:`CTRL_PAR_LO]),
    .two_stop(ctrl_q[`CTRL_TWO_STOP]),
    .bit_clks(bit_clocks(ctrl_q[`CTRL_BAUD_HI:`CTRL_BAUD_LO])),
    .ready(uart_ready),
    .txd(txd)
  );
  // RTU request filter; in master mode frames are replies and pass unfiltered
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      rx_accept <= 1'b0;
    else
      rx_accept <= rx_addr_valid && (cfg_master || (rx_addr == own_addr_q));
  end
  // TCP slave: every unit accepted, own address not consulted
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tcp_req_accept <= 1'b0;
      tcp_req_unit_out <= 8'h00;
    end else begin
      tcp_req_accept <= tcp_req_valid;
      if (tcp_req_valid) tcp_req_unit_out <= tcp_req_unit;
    end
  end
  // TCP master lookup: unit selects IP, then route local or via next hop
  reg [31:0] look_ip;
  reg look_hit;
  integer i;
  always @* begin
    look_ip = 32'h00000000;
    look_hit = 1'b0;
    for (i = MAP_N - 1; i >= 0; i = i - 1) begin
      if (map_unit_q[i] == tcp_q_unit) begin
        look_ip = map_ip_q[i];
        look_hit = 1'b1;
      end
    end
  end
  wire off_net = ((look_ip & mask_q) != (ip_live_q & mask_q));
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tcp_q_found <= 1'b0;
      tcp_dest_ip <= 32'h00000000;
      tcp_hop_ip <= 32'h00000000;
      tcp_q_done <= 1'b0;
    end else begin
      tcp_q_done <= tcp_q_valid;
      if (tcp_q_valid) begin
        tcp_q_found <= look_hit;
        tcp_dest_ip <= look_ip;
        // Zero router: all slaves local
        tcp_hop_ip <= ((hop_q != 32'h00000000) && off_net) ? hop_q : look_ip;
      end
    end
  end
  // TCP reply timer; the same timeout setting applies on this side
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tcp_wait_q <= 1'b0;
      tcp_ms_q <= 16'h0000;
      tcp_no_reply <= 1'b0;
    end else begin
      tcp_no_reply <= 1'b0;
      if (ms_tick && (tcp_ms_q != 16'hFFFF)) tcp_ms_q <= tcp_ms_q + 16'h0001;
      if (tcp_q_valid && look_hit) begin
        tcp_ms_q <= 16'h0000;
        tcp_wait_q <= (tmo_q != 8'h00);
        tcp_no_reply <= (tmo_q == 8'h00);
      end else if (tcp_wait_q && tcp_reply_seen) begin
        tcp_wait_q <= 1'b0;
      end else if (tcp_wait_q && (tcp_ms_q >= tmo_ms)) begin
        tcp_wait_q <= 1'b0;
        tcp_no_reply <= 1'b1;
      end
    end
  end
  // Word order: master per register, slave global
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wo_reg_lo <= 16'h0000;
      wo_reg_hi <= 16'h0000;
      wo_done <= 1'b0;
    end else begin
      wo_done <= wo_valid;
      if (wo_valid) begin
        {wo_reg_hi, wo_reg_lo} <= order_words(wo_value, wo_is32,
                                              wo_master_side ? wo_map_hi_first : cfg_hi_first);
      end
    end
  end
endmodule // modbus_port

/* File: testbench/modbus_port_sva.sv */
// Port-level timing checker of the Modbus port
module modbus_port_sva (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire txd,
  input wire line_drive,
  input wire reply_seen,
  input wire reply_ok,
  input wire no_reply,
  input wire rx_addr_valid,
  input wire rx_accept,
  input wire tcp_req_valid,
  input wire [7:0] tcp_req_unit,
  input wire tcp_req_accept,
  input wire [7:0] tcp_req_unit_out,
  input wire tcp_q_valid,
  input wire tcp_q_done,
  input wire [31:0] own_ip,
  input wire wo_valid,
  input wire wo_is32,
  input wire wo_master_side,
  input wire wo_map_hi_first,
  input wire [31:0] wo_value,
  input wire [15:0] wo_reg_lo,
  input wire [15:0] wo_reg_hi,
  input wire wo_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Master asks for high-first split of a 32-bit value
  sequence s_wo_master_hi;
    wo_valid && wo_is32 && wo_master_side && wo_map_hi_first;
  endsequence
  // Upper half lands in the lower register
  sequence s_wo_split_hi;
    wo_done && wo_reg_lo == $past(wo_value[31:16]) && wo_reg_hi == $past(wo_value[15:0]);
  endsequence
  a_wo_master_hi: assert property (s_wo_master_hi |=> s_wo_split_hi)
    else $error("master high-first split wrong");
  a_wo_narrow: assert property (wo_valid && !wo_is32 |=> wo_done
    && wo_reg_lo == $past(wo_value[15:0]) && wo_reg_hi == 16'h0000)
    else $error("16-bit value altered");
  a_wo_pair_whole: assert property (wo_valid && wo_is32 |=>
    {wo_reg_lo, wo_reg_hi} == $past(wo_value) || {wo_reg_hi, wo_reg_lo} == $past(wo_value))
    else $error("32-bit value not kept in two registers");
  a_rx_accept_cause: assert property (rx_accept |-> $past(rx_addr_valid))
    else $error("accept without a received address");
  a_tcp_any_unit: assert property (tcp_req_valid |=> tcp_req_accept
    && tcp_req_unit_out == $past(tcp_req_unit))
    else $error("tcp request not accepted");
  a_tcp_query_done: assert property (tcp_q_valid |=> tcp_q_done)
    else $error("tcp query lookup missing");
  a_drive_data: assert property ($fell(txd) |-> line_drive)
    else $error("start bit with driver off");
  a_drive_release: assert property ($fell(line_drive) |-> $past(txd) && txd)
    else $error("driver released inside a character");
  a_ip_restart: assert property (!$stable(own_ip) |-> $past(reg_wr)
    && $past(reg_addr) == 8'h00 && $past(reg_wdata[8]))
    else $error("live IP changed without restart");
  a_reply_cause: assert property (reply_ok |-> $past(reply_seen) && !no_reply)
    else $error("reply flagged without a reply");
endmodule // modbus_port_sva

bind modbus_port modbus_port_sva i_modbus_port_sva (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .txd(txd),
  .line_drive(line_drive), .reply_seen(reply_seen), .reply_ok(reply_ok), .no_reply(no_reply),
  .rx_addr_valid(rx_addr_valid), .rx_accept(rx_accept), .tcp_req_valid(tcp_req_valid),
  .tcp_req_unit(tcp_req_unit), .tcp_req_accept(tcp_req_accept),
  .tcp_req_unit_out(tcp_req_unit_out), .tcp_q_valid(tcp_q_valid), .tcp_q_done(tcp_q_done),
  .own_ip(own_ip), .wo_valid(wo_valid), .wo_is32(wo_is32), .wo_master_side(wo_master_side),
  .wo_map_hi_first(wo_map_hi_first), .wo_value(wo_value), .wo_reg_lo(wo_reg_lo),
  .wo_reg_hi(wo_reg_hi), .wo_done(wo_done));

/* File: testbench/modbus_far_slave.sv */
// Behavioural far-side station on the RS-485 line
module modbus_far_slave #(
  parameter int BIT_CLKS = 520
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic line_drive,
  input wire logic reply_en,
  input wire logic [15:0] reply_dly,
  output logic reply_seen,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reply_seen = 1'b0;
  // Mid-bit sampling, LSB first; parity and stops skipped
  always begin
    @(negedge txd);
    if (line_drive) begin
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        got_byte[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge clk);
    end
  end
  // Answer after driver release; long delays stress the timeout
  always @(negedge line_drive) begin
    if (reply_en) begin
      repeat (reply_dly) @(posedge clk);
      reply_seen <= 1'b1;
      @(posedge clk);
      reply_seen <= 1'b0;
    end
  end
endmodule // modbus_far_slave

/* File: testbench/modbus_port_tb.sv */
// Self-checking bench of the Modbus port
`include "modbus_port_defs.vh"
module modbus_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 20; // Short millisecond keeps the run brief
  logic clk, sys_rst, reg_wr, reg_rd, tx_valid, tx_last, rx_addr_valid, tcp_req_valid;
  logic tcp_q_valid, wo_valid, wo_is32, wo_master_side, wo_map_hi_first, reply_en;
  logic [7:0] reg_addr, tx_data, rx_addr, tcp_req_unit, tcp_q_unit, got_byte, tcp_req_unit_out;
  logic [31:0] reg_wdata, reg_rdata, wo_value, tcp_dest_ip, tcp_hop_ip, own_ip, rdv;
  logic [15:0] tcp_port, wo_reg_lo, wo_reg_hi, reply_dly;
  logic tx_ready, txd, line_drive, reply_seen, reply_ok, no_reply, rx_accept, tcp_req_accept;
  logic tcp_q_found, tcp_q_done, tcp_no_reply, wo_done, ld_q, txd_q;
  int checks, n_fail, cyc, t_on, t_off, lead_n, gap, n, nr_at, tnr_at;

  modbus_port #(.CLKS_PER_MS(CPM), .MAP_N(4)) i_modbus_port (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .txd(txd), .line_drive(line_drive), .reply_seen(reply_seen),
    .reply_ok(reply_ok), .no_reply(no_reply), .rx_addr_valid(rx_addr_valid),
    .rx_addr(rx_addr), .rx_accept(rx_accept), .tcp_req_valid(tcp_req_valid),
    .tcp_req_unit(tcp_req_unit), .tcp_req_accept(tcp_req_accept),
    .tcp_req_unit_out(tcp_req_unit_out), .tcp_q_valid(tcp_q_valid), .tcp_q_unit(tcp_q_unit),
    .tcp_reply_seen(1'b0), .tcp_q_found(tcp_q_found), .tcp_dest_ip(tcp_dest_ip),
    .tcp_hop_ip(tcp_hop_ip), .tcp_q_done(tcp_q_done), .tcp_no_reply(tcp_no_reply),
    .tcp_port(tcp_port), .own_ip(own_ip), .wo_valid(wo_valid), .wo_is32(wo_is32),
    .wo_master_side(wo_master_side), .wo_map_hi_first(wo_map_hi_first), .wo_value(wo_value),
    .wo_reg_lo(wo_reg_lo), .wo_reg_hi(wo_reg_hi), .wo_done(wo_done));
  modbus_far_slave #(.BIT_CLKS(520)) i_modbus_far_slave (.clk(clk), .txd(txd),
    .line_drive(line_drive), .reply_en(reply_en), .reply_dly(reply_dly),
    .reply_seen(reply_seen), .got_byte(got_byte));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Line monitor: driver edges, lead time, gap, error pulses
  always @(posedge clk) begin
    cyc++;
    if (line_drive && !ld_q) begin
      gap = cyc - t_off;
      t_on = cyc;
      lead_n = -1;
    end
    if (!line_drive && ld_q) t_off = cyc;
    if (line_drive && !txd && txd_q && lead_n < 0) lead_n = cyc - t_on;
    if (no_reply) nr_at = cyc;
    if (tcp_no_reply) tnr_at = cyc;
    ld_q = line_drive;
    txd_q = txd;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // One-byte frame, returns once the driver is off
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    tx_valid <= 1'b1; tx_data <= b;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    tx_valid <= 1'b0;
    @(posedge clk);
    while (line_drive !== 1'b0) @(posedge clk);
  endtask
  task automatic rxp(input logic [7:0] a, input logic exp);
    @(posedge clk);
    rx_addr_valid <= 1'b1; rx_addr <= a;
    @(posedge clk);
    rx_addr_valid <= 1'b0;
    @(negedge clk);
    chk("rx_accept", exp, rx_accept);
  endtask
  task automatic wop(input logic is32, ms, mhi, input logic [15:0] lo, hi);
    @(posedge clk);
    wo_valid <= 1'b1; wo_is32 <= is32; wo_master_side <= ms; wo_map_hi_first <= mhi;
    @(posedge clk);
    wo_valid <= 1'b0;
    @(negedge clk);
    chk("wo_reg_lo", lo, wo_reg_lo);
    chk("wo_reg_hi", hi, wo_reg_hi);
  endtask
  task automatic tq(input logic [7:0] u, input logic f, input logic [31:0] dst, hop);
    @(posedge clk);
    tcp_q_valid <= 1'b1; tcp_q_unit <= u;
    @(posedge clk);
    tcp_q_valid <= 1'b0;
    @(negedge clk);
    chk("tcp_q_found", f, tcp_q_found);
    chk("tcp_dest_ip", dst, tcp_dest_ip);
    chk("tcp_hop_ip", hop, tcp_hop_ip);
  endtask

  task automatic t_reset();
    rd(`REG_IP_LIVE, rdv); chk("reset ip", `RST_IP, rdv);
    rd(`REG_TCP_PORT, rdv); chk("reset port", 32'h1F6, rdv);
    chk("tcp_port", 32'h1F6, tcp_port);
    rd(`REG_NEXT_HOP, rdv); chk("next hop", 32'h0, rdv);
    rd(8'h3C, rdv); chk("unmapped", 32'h0, rdv);
  endtask
  task automatic t_order();
    wop(1'b0, 1'b0, 1'b1, 16'h5678, 16'h0000);
    wop(1'b1, 1'b1, 1'b1, 16'h1234, 16'h5678);
    wop(1'b1, 1'b1, 1'b0, 16'h5678, 16'h1234);
    wop(1'b1, 1'b0, 1'b0, 16'h1234, 16'h5678);
    wr(`REG_CTRL, 32'h0A1);
    wop(1'b1, 1'b0, 1'b1, 16'h5678, 16'h1234);
    wop(1'b0, 1'b0, 1'b0, 16'h5678, 16'h0000);
  endtask
  task automatic t_addr();
    wr(`REG_CTRL, 32'h0A2);
    wr(`REG_OWN_ADDR, 32'h11);
    rxp(8'h11, 1'b1);
    rxp(8'h12, 1'b0);
    wr(`REG_CTRL, 32'h0A3);
    rxp(8'h12, 1'b1);
  endtask
  task automatic t_serial();
    wr(`REG_LEAD_MS, 32'h2);
    wr(`REG_REPLY_TMO, 32'h1);
    reply_en = 1'b1;
    send(8'hA5);
    chk("lead", 1, lead_n >= 2 * CPM && lead_n <= 2 * CPM + 4);
    chk("byte", 8'hA5, got_byte);
    n = 0;
    while (reply_ok !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("reply_ok", 1, reply_ok);
    reply_en = 1'b0;
    send(8'h3C);
    n = 0;
    while (nr_at < t_off && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("timeout", 1, nr_at - t_off >= 100 * CPM - 25 && nr_at - t_off <= 100 * CPM + 45);
    wr(`REG_REPLY_TMO, 32'h0);
    send(8'h5A);
    repeat (4) @(posedge clk);
    chk("zero timeout", 1, nr_at - t_off >= -1 && nr_at - t_off <= 3);
    send(8'hC3);
    chk("gap", 1, gap >= 2 * CPM);
  endtask
  task automatic t_tcp();
    @(posedge clk);
    tcp_req_valid <= 1'b1; tcp_req_unit <= 8'h37;
    @(posedge clk);
    tcp_req_valid <= 1'b0;
    @(negedge clk);
    chk("req accept", 1, tcp_req_accept);
    chk("req unit", 8'h37, tcp_req_unit_out);
    wr(`REG_MAP_SEL, 32'h0); wr(`REG_MAP_UNIT, 32'h5); wr(`REG_MAP_IP, 32'h0A000010);
    wr(`REG_MAP_SEL, 32'h1); wr(`REG_MAP_UNIT, 32'h6); wr(`REG_MAP_IP, 32'hC0A80105);
    tq(8'h06, 1'b1, 32'hC0A80105, 32'hC0A80105);
    repeat (3) @(posedge clk);
    chk("tcp timeout", 1, cyc - tnr_at <= 5);
    wr(`REG_NEXT_HOP, 32'h0A000001);
    tq(8'h06, 1'b1, 32'hC0A80105, 32'h0A000001);
    tq(8'h05, 1'b1, 32'h0A000010, 32'h0A000010);
  endtask
  task automatic t_ip();
    wr(`REG_IP_NEXT, 32'hC0A80194);
    rd(`REG_IP_LIVE, rdv); chk("live ip", `RST_IP, rdv);
    wr(`REG_CTRL, 32'h1A3);
    @(negedge clk);
    chk("own ip", 32'hC0A80194, own_ip);
  endtask

  task automatic final_report();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog well beyond the expected 25k cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    tx_valid = 1'b0; tx_data = 8'h00; tx_last = 1'b1; rx_addr_valid = 1'b0; rx_addr = 8'h00;
    tcp_req_valid = 1'b0; tcp_req_unit = 8'h00; tcp_q_valid = 1'b0; tcp_q_unit = 8'h00;
    wo_valid = 1'b0; wo_is32 = 1'b0; wo_master_side = 1'b0; wo_map_hi_first = 1'b0;
    wo_value = 32'h12345678; reply_en = 1'b0; reply_dly = 16'h05DC; ld_q = 1'b0; txd_q = 1'b1;
    nr_at = -1; tnr_at = -1000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_order();
    t_addr();
    t_serial();
    t_tcp();
    t_ip();
    final_report();
  end
endmodule // modbus_port_tb
